// ### rtl/clock_startup_pkg.sv
package clock_startup_pkg;

    // counter width, wide enough for the longest count
    localparam int CNT_W = 17;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h08;
    localparam logic [7:0] COUNT_OFFSET = 8'h0c;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_GO_BIT = 3;
    localparam logic [2:0] CTRL_MODE_RESET = 3'h0;

    // status register fields
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_ERR_BIT = 3;
    localparam int STATUS_BUSY_BIT = 4;
    localparam int STATUS_DOMAIN_LSB = 5;

    // config register fields
    localparam int CONFIG_CKSEL_LSB = 0;
    localparam int CONFIG_SUT_LSB = 4;
    localparam int CONFIG_DIV8_BIT = 6;
    localparam int CONFIG_SRC_LSB = 7;
    localparam int CONFIG_AMP_LSB = 10;

    // source select codes
    localparam logic [3:0] CODE_EXT_CLK = 4'h0;
    localparam logic [3:0] CODE_RC_OSC = 4'h2;
    localparam logic [3:0] CODE_LF_SHORT = 4'h6;
    localparam logic [3:0] CODE_LF_LONG = 4'h7;

    // cycle counts
    localparam logic [CNT_W-1:0] CK_6 = 17'h00006;
    localparam logic [CNT_W-1:0] CK_14 = 17'h0000e;
    localparam logic [CNT_W-1:0] CK_258 = 17'h00102;
    localparam logic [CNT_W-1:0] CK_1K = 17'h00400;
    localparam logic [CNT_W-1:0] WDT_4K = 17'h01000;
    localparam logic [CNT_W-1:0] CK_NONE = 17'h00000;
    localparam logic [CNT_W-1:0] SETTLE_CYCLES = 17'h00003;

    // shipped fuse setting: rc oscillator, start-up 10, divide-by-8 programmed
    localparam logic [6:0] FUSE_DEFAULT = 7'h14;
    localparam logic [3:0] WAKE_SYNC_RESET = 4'h0;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_XTAL = 3'h1,
        SRC_LF_XTAL = 3'h2,
        SRC_RC = 3'h3,
        SRC_EXT = 3'h4
    } source_t;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'h0,
        MODE_ADC_NR = 3'h1,
        MODE_PDOWN = 3'h2,
        MODE_PSAVE = 3'h3,
        MODE_STANDBY = 3'h6
    } sleep_mode_t;

    typedef enum logic [2:0] {
        ST_LOAD = 3'b000,
        ST_RESET_CK = 3'b001,
        ST_RESET_WDT = 3'b011,
        ST_RUN = 3'b010,
        ST_SLEEP = 3'b110,
        ST_WAKE = 3'b111,
        ST_ERR = 3'b100
    } state_t;

    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic async_tmr;
        logic adc;
    } domain_en_t;

    typedef struct packed {
        logic [3:0] cksel;
        logic [1:0] sut;
        logic div8;
    } fuse_t;

    typedef struct packed {
        source_t src;
        logic [2:0] amp_mode;
        logic [CNT_W-1:0] wake_cycles;
        logic [CNT_W-1:0] wdt_cycles;
        logic bad;
    } cfg_t;

endpackage

// ### rtl/clock_source_startup_control.sv
`timescale 1ns/100ps
// Behaviour
// RULE1: decode source fuses into crystal, lf, rc, external
// RULE2: fuse bit one unprogrammed, zero programmed
// RULE3: wake from deep sleep counts source cycles
// RULE4: reset adds 4096 or 65536 watchdog cycles
// RULE5: default fuses: rc, start-up 10, divide-by-8
// RULE6: crystal amplifier mode from upper three bits
// RULE7: crystal lowest bit plus start-up bits pick delays
// RULE8: lf crystal reset delay from start-up bits
// RULE9: lf crystal wake count 1K or 32K
// RULE10: sleep modes gate unused module clocks
// RULE11: core clock domain gates all core work
// RULE12: io domain; async interrupts wake while stopped
// RULE13: serial start detect works in every sleep
// RULE14: flash domain follows core clock
// RULE15: async timer domain runs while device sleeps; code stops it in power-down and standby
// RULE16: adc domain stays on during noise reduction
// RULE17: selected source routed into clock generator
// RULE18: rc or external: 6 cycle wake, reset delays
// RULE19: core gated until counts done; reserved codes fault
module clock_source_startup_control #(
    parameter int WDT_LONG_CYCLES = 65536,
    parameter int XTAL_LONG_WAKE = 16384,
    parameter int LF_LONG_WAKE = 32768
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration fuses
    input wire logic [3:0] clock_source_select_fuses_i,
    input wire logic [1:0] startup_time_select_fuses_i,
    input wire logic initial_divide_by_eight_fuse_i,
    // oscillator ticks
    input wire logic source_clk_i,
    input wire logic watchdog_osc_clk_i,
    // asynchronous wake detectors
    input wire logic ext_int_async_i,
    input wire logic usi_start_async_i,
    // clock generator control
    output clock_startup_pkg::domain_en_t domain_en_o,
    output clock_startup_pkg::source_t source_sel_o,
    output logic [2:0] crystal_amplifier_mode_bits_o,
    output logic divide_by_eight_o,
    output logic startup_busy_o,
    output logic config_error_o
);

    localparam logic [clock_startup_pkg::CNT_W-1:0] WDT_64K =
        clock_startup_pkg::CNT_W'(WDT_LONG_CYCLES);
    localparam logic [clock_startup_pkg::CNT_W-1:0] CK_16K =
        clock_startup_pkg::CNT_W'(XTAL_LONG_WAKE);
    localparam logic [clock_startup_pkg::CNT_W-1:0] CK_32K =
        clock_startup_pkg::CNT_W'(LF_LONG_WAKE);

    // reset delay shared by rc, external and lf crystal
    function automatic logic [clock_startup_pkg::CNT_W-1:0] sut_delay(input logic [1:0] sut);
        case (sut)
            2'h0: sut_delay = clock_startup_pkg::CK_NONE;
            2'h1: sut_delay = clock_startup_pkg::WDT_4K;
            default: sut_delay = WDT_64K;
        endcase
    endfunction

    function automatic clock_startup_pkg::cfg_t decode_cfg(input clock_startup_pkg::fuse_t f);
        clock_startup_pkg::cfg_t c;
        c = '0;
        c.src = clock_startup_pkg::SRC_NONE;
        c.amp_mode = 3'h0;
        c.bad = 1'b0;
        if (f.cksel[3]) begin // see RULE1
            c.src = clock_startup_pkg::SRC_XTAL;
            c.amp_mode = f.cksel[3:1]; // see RULE6
            case ({f.cksel[0], f.sut}) // see RULE7
                3'h0: begin
                    c.wake_cycles = clock_startup_pkg::CK_258;
                    c.wdt_cycles = clock_startup_pkg::WDT_4K;
                end
                3'h1: begin
                    c.wake_cycles = clock_startup_pkg::CK_258;
                    c.wdt_cycles = WDT_64K;
                end
                3'h2: begin
                    c.wake_cycles = clock_startup_pkg::CK_1K;
                    c.wdt_cycles = clock_startup_pkg::CK_NONE;
                end
                3'h3: begin
                    c.wake_cycles = clock_startup_pkg::CK_1K;
                    c.wdt_cycles = clock_startup_pkg::WDT_4K;
                end
                3'h4: begin
                    c.wake_cycles = clock_startup_pkg::CK_1K;
                    c.wdt_cycles = WDT_64K;
                end
                3'h5: begin
                    c.wake_cycles = CK_16K;
                    c.wdt_cycles = clock_startup_pkg::CK_NONE;
                end
                3'h6: begin
                    c.wake_cycles = CK_16K;
                    c.wdt_cycles = clock_startup_pkg::WDT_4K;
                end
                default: begin
                    c.wake_cycles = CK_16K;
                    c.wdt_cycles = WDT_64K;
                end
            endcase
        end else begin
            case (f.cksel)
                clock_startup_pkg::CODE_LF_SHORT, clock_startup_pkg::CODE_LF_LONG: begin
                    c.src = clock_startup_pkg::SRC_LF_XTAL; // see RULE1
                    c.wake_cycles = f.cksel[0] ? CK_32K : clock_startup_pkg::CK_1K; // see RULE9
                    c.wdt_cycles = sut_delay(f.sut); // see RULE8
                end
                clock_startup_pkg::CODE_RC_OSC: begin
                    c.src = clock_startup_pkg::SRC_RC; // see RULE1
                    c.wake_cycles = clock_startup_pkg::CK_6; // see RULE18
                    c.wdt_cycles = sut_delay(f.sut);
                end
                clock_startup_pkg::CODE_EXT_CLK: begin
                    c.src = clock_startup_pkg::SRC_EXT; // see RULE1
                    c.wake_cycles = clock_startup_pkg::CK_6; // see RULE18
                    c.wdt_cycles = sut_delay(f.sut);
                end
                default: c.bad = 1'b1; // see RULE19
            endcase
            if (f.sut == 2'h3) begin
                c.bad = 1'b1; // see RULE19
            end
        end
        decode_cfg = c;
    endfunction

    // module clock domains for each state and sleep mode
    function automatic clock_startup_pkg::domain_en_t domains(
        input clock_startup_pkg::state_t st,
        input logic [2:0] mode
    );
        clock_startup_pkg::domain_en_t d;
        d = '0;
        if (st == clock_startup_pkg::ST_RUN) begin
            d = '1;
        end else if (st == clock_startup_pkg::ST_SLEEP || st == clock_startup_pkg::ST_WAKE) begin
            case (mode) // see RULE10
                clock_startup_pkg::MODE_ADC_NR: begin
                    d.adc = 1'b1; // see RULE16
                    d.async_tmr = 1'b1;
                end
                clock_startup_pkg::MODE_PDOWN, clock_startup_pkg::MODE_STANDBY: d = '0;
                clock_startup_pkg::MODE_PSAVE: d.async_tmr = 1'b1; // see RULE15
                default: begin
                    d.io = 1'b1;
                    d.adc = 1'b1;
                    d.async_tmr = 1'b1;
                end
            endcase
        end
        d.flash = d.core; // see RULE14
        domains = d;
    endfunction

    // pin synchronisers: fuses, then the two oscillators and the two wake detectors
    logic [6:0] fuse_sync1_reg;
    logic [6:0] fuse_sync2_reg;
    logic [3:0] osc_sync1_reg;
    logic [3:0] osc_sync2_reg;
    logic [1:0] osc_prev_reg;
    logic src_edge;
    logic wdt_edge;
    logic wake_event;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            fuse_sync1_reg <= clock_startup_pkg::FUSE_DEFAULT; // see RULE5
            fuse_sync2_reg <= clock_startup_pkg::FUSE_DEFAULT;
        end else begin
            // raw levels kept: a zero is a programmed fuse
            fuse_sync1_reg <= {clock_source_select_fuses_i, startup_time_select_fuses_i,
                               initial_divide_by_eight_fuse_i}; // see RULE2
            fuse_sync2_reg <= fuse_sync1_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            osc_sync1_reg <= clock_startup_pkg::WAKE_SYNC_RESET;
            osc_sync2_reg <= clock_startup_pkg::WAKE_SYNC_RESET;
            osc_prev_reg <= 2'h0;
        end else begin
            osc_sync1_reg <= {usi_start_async_i, ext_int_async_i,
                              watchdog_osc_clk_i, source_clk_i};
            osc_sync2_reg <= osc_sync1_reg;
            osc_prev_reg <= osc_sync2_reg[1:0];
        end
    end

    assign src_edge = osc_sync2_reg[0] & ~osc_prev_reg[0];
    assign wdt_edge = osc_sync2_reg[1] & ~osc_prev_reg[1];
    assign wake_event = osc_sync2_reg[2] | osc_sync2_reg[3]; // see RULE12 see RULE13

    // state and counters
    clock_startup_pkg::state_t state_reg;
    clock_startup_pkg::state_t state_next;
    logic [clock_startup_pkg::CNT_W-1:0] cnt_reg;
    logic [clock_startup_pkg::CNT_W-1:0] cnt_next;
    clock_startup_pkg::fuse_t fuse_reg;
    clock_startup_pkg::cfg_t cfg_reg;
    clock_startup_pkg::cfg_t cfg_live;
    logic [2:0] mode_reg;
    logic go_reg;

    assign cfg_live = decode_cfg(fuse_sync2_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            clock_startup_pkg::ST_LOAD: begin
                if (cnt_reg == clock_startup_pkg::SETTLE_CYCLES - 17'h00001) begin
                    state_next = cfg_live.bad ? clock_startup_pkg::ST_ERR :
                        clock_startup_pkg::ST_RESET_CK; // see RULE19
                end
            end
            clock_startup_pkg::ST_RESET_CK: begin
                if (src_edge && cnt_reg == clock_startup_pkg::CK_14 - 17'h00001) begin
                    state_next = (cfg_reg.wdt_cycles == clock_startup_pkg::CK_NONE) ?
                        clock_startup_pkg::ST_RUN : clock_startup_pkg::ST_RESET_WDT;
                end
            end
            clock_startup_pkg::ST_RESET_WDT: begin
                if (wdt_edge && cnt_reg == cfg_reg.wdt_cycles - 17'h00001) begin
                    state_next = clock_startup_pkg::ST_RUN; // see RULE4 see RULE19
                end
            end
            clock_startup_pkg::ST_RUN: begin
                if (go_reg) begin
                    state_next = clock_startup_pkg::ST_SLEEP;
                end
            end
            clock_startup_pkg::ST_SLEEP: begin
                if (wake_event) begin
                    state_next = (mode_reg == clock_startup_pkg::MODE_PDOWN ||
                                  mode_reg == clock_startup_pkg::MODE_PSAVE) ?
                        clock_startup_pkg::ST_WAKE : clock_startup_pkg::ST_RUN;
                end
            end
            clock_startup_pkg::ST_WAKE: begin
                if (src_edge && cnt_reg == cfg_reg.wake_cycles - 17'h00001) begin
                    state_next = clock_startup_pkg::ST_RUN; // see RULE3
                end
            end
            clock_startup_pkg::ST_ERR: state_next = clock_startup_pkg::ST_ERR;
            default: state_next = clock_startup_pkg::ST_LOAD;
        endcase
    end

    always_comb begin
        cnt_next = cnt_reg;
        if (state_next != state_reg) begin
            cnt_next = '0;
        end else if (state_reg == clock_startup_pkg::ST_LOAD) begin
            cnt_next = cnt_reg + 17'h00001;
        end else if ((state_reg == clock_startup_pkg::ST_RESET_CK ||
                      state_reg == clock_startup_pkg::ST_WAKE) && src_edge) begin
            cnt_next = cnt_reg + 17'h00001; // see RULE3
        end else if (state_reg == clock_startup_pkg::ST_RESET_WDT && wdt_edge) begin
            cnt_next = cnt_reg + 17'h00001; // see RULE4
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            state_reg <= clock_startup_pkg::ST_LOAD;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // configuration captured once the fuse levels have settled
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            fuse_reg <= clock_startup_pkg::FUSE_DEFAULT;
            cfg_reg <= '0;
        end else if (state_reg == clock_startup_pkg::ST_LOAD &&
                     state_next != clock_startup_pkg::ST_LOAD) begin
            fuse_reg <= fuse_sync2_reg;
            cfg_reg <= cfg_live;
        end
    end

    // clock generator outputs
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            domain_en_o <= '0;
            source_sel_o <= clock_startup_pkg::SRC_NONE;
            crystal_amplifier_mode_bits_o <= 3'h0;
            divide_by_eight_o <= 1'b1;
            startup_busy_o <= 1'b1;
            config_error_o <= 1'b0;
        end else begin
            domain_en_o <= domains(state_next, mode_reg); // see RULE11 see RULE19
            source_sel_o <= cfg_reg.src; // see RULE17
            crystal_amplifier_mode_bits_o <= cfg_reg.amp_mode;
            divide_by_eight_o <= ~fuse_reg.div8; // see RULE5
            startup_busy_o <= state_next != clock_startup_pkg::ST_RUN &&
                              state_next != clock_startup_pkg::ST_SLEEP;
            config_error_o <= state_next == clock_startup_pkg::ST_ERR;
        end
    end

    // wishbone slave
    logic take;
    logic wr;
    logic [31:0] rd_data;

    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == clock_startup_pkg::CTRL_OFFSET);

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            mode_reg <= clock_startup_pkg::CTRL_MODE_RESET;
            go_reg <= 1'b0;
        end else begin
            if (wr) begin
                mode_reg <= wb_dat_i[clock_startup_pkg::CTRL_MODE_LSB +: 3];
            end
            go_reg <= wr & wb_dat_i[clock_startup_pkg::CTRL_GO_BIT] &
                      (state_reg == clock_startup_pkg::ST_RUN);
        end
    end

    always_comb begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            clock_startup_pkg::CTRL_OFFSET: begin
                rd_data[clock_startup_pkg::CTRL_MODE_LSB +: 3] = mode_reg;
            end
            clock_startup_pkg::STATUS_OFFSET: begin
                rd_data[clock_startup_pkg::STATUS_STATE_LSB +: 3] = state_reg;
                rd_data[clock_startup_pkg::STATUS_ERR_BIT] = config_error_o;
                rd_data[clock_startup_pkg::STATUS_BUSY_BIT] = startup_busy_o;
                rd_data[clock_startup_pkg::STATUS_DOMAIN_LSB +: 5] = domain_en_o;
            end
            clock_startup_pkg::CONFIG_OFFSET: begin
                rd_data[clock_startup_pkg::CONFIG_CKSEL_LSB +: 4] = fuse_reg.cksel;
                rd_data[clock_startup_pkg::CONFIG_SUT_LSB +: 2] = fuse_reg.sut;
                rd_data[clock_startup_pkg::CONFIG_DIV8_BIT] = fuse_reg.div8;
                rd_data[clock_startup_pkg::CONFIG_SRC_LSB +: 3] = cfg_reg.src;
                rd_data[clock_startup_pkg::CONFIG_AMP_LSB +: 3] = cfg_reg.amp_mode;
            end
            clock_startup_pkg::COUNT_OFFSET: begin
                rd_data[clock_startup_pkg::CNT_W-1:0] = cnt_reg;
            end
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= take;
            wb_dat_o <= take ? rd_data : 32'h00000000;
        end
    end

endmodule

// ### bench/clock_startup_properties.sv
`timescale 1ns/100ps
module clock_startup_properties #(
    parameter int WDT_LONG_CYCLES = 65536,
    parameter int XTAL_LONG_WAKE = 16384,
    parameter int LF_LONG_WAKE = 32768
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // clock generator control
    input wire clock_startup_pkg::domain_en_t domain_en_o,
    input wire clock_startup_pkg::source_t source_sel_o,
    input wire logic [2:0] crystal_amplifier_mode_bits_o,
    input wire logic startup_busy_o,
    input wire logic config_error_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    busy_gates_core_a: assert property (startup_busy_o |-> !domain_en_o.core)
        else $error("core clock on during start-up");
    error_sticky_a: assert property (config_error_o |=> config_error_o && !domain_en_o.core)
        else $error("config error released or core on");
    flash_follows_core_a: assert property (domain_en_o.flash == domain_en_o.core)
        else $error("flash domain differs from core");
    run_all_on_a: assert property (domain_en_o.core |-> domain_en_o == 5'h1f)
        else $error("core on without all domains");
    async_kept_a: assert property (domain_en_o.adc |-> domain_en_o.async_tmr)
        else $error("adc on without async timer");
    adc_kept_a: assert property (domain_en_o.io |-> domain_en_o.adc)
        else $error("io on without adc domain");
    amp_idle_a: assert property (source_sel_o != clock_startup_pkg::SRC_XTAL
        |-> crystal_amplifier_mode_bits_o == 3'h0)
        else $error("amplifier mode set off crystal");
    amp_range_a: assert property (source_sel_o == clock_startup_pkg::SRC_XTAL
        |-> crystal_amplifier_mode_bits_o[2])
        else $error("amplifier mode below 100");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle pulse");
    dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");

    cover property (domain_en_o.core);
    cover property (config_error_o);
    cover property (!startup_busy_o && !domain_en_o.core);
endmodule

// ### bench/osc_source_model.sv
`timescale 1ns/100ps
module osc_source_model #(
    parameter int SRC_HALF_NS = 20,
    parameter int WDT_HALF_NS = 15
) (
    // oscillator outputs
    output logic source_clk_o,
    output logic watchdog_clk_o
);
    // selected source, slower than a quarter of the system clock
    initial begin
        source_clk_o = 1'b0;
        #3;
        forever #(SRC_HALF_NS) source_clk_o = ~source_clk_o;
    end
    // watchdog oscillator times the reset delay
    initial begin
        watchdog_clk_o = 1'b0;
        #7;
        forever #(WDT_HALF_NS) watchdog_clk_o = ~watchdog_clk_o;
    end
endmodule

// ### bench/clock_source_startup_control_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD at %0t got %0h exp %0h", $time, g, e); end end
module clock_source_startup_control_tb;
    logic mclk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, div8, ext_int, usi_start;
    logic wb_ack_o, src_clk, wdt_clk, busy, err, d8_out;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, exp;
    logic [3:0] cks;
    logic [1:0] sut;
    logic [2:0] amp, ae;
    clock_startup_pkg::domain_en_t dom;
    clock_startup_pkg::source_t src;
    int failures, comparisons, cycles, n, lo;
    logic [3:0] cks_tab [13] = '{4'h2, 4'hf, 4'h9, 4'h7, 4'h6, 4'h0, 4'h3, 4'h1, 4'h5, 4'h4,
        4'h2, 4'h6, 4'h0};
    logic [1:0] sut_tab [13] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h3, 2'h3, 2'h3};
    int wdt_tab [6] = '{64, 0, 64, 4096, 64, 0};
    logic [2:0] mode_tab [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6};
    logic [4:0] dom_tab [5] = '{5'h07, 5'h03, 5'h02, 5'h00, 5'h00};
    int wake_tab [5] = '{0, 0, 40, 40, 0};

    clock_source_startup_control #(.WDT_LONG_CYCLES(64), .XTAL_LONG_WAKE(32),
        .LF_LONG_WAKE(48)) dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clock_source_select_fuses_i(cks),
        .startup_time_select_fuses_i(sut), .initial_divide_by_eight_fuse_i(div8),
        .source_clk_i(src_clk), .watchdog_osc_clk_i(wdt_clk), .ext_int_async_i(ext_int),
        .usi_start_async_i(usi_start), .domain_en_o(dom), .source_sel_o(src),
        .crystal_amplifier_mode_bits_o(amp), .divide_by_eight_o(d8_out),
        .startup_busy_o(busy), .config_error_o(err));
    osc_source_model osc (.source_clk_o(src_clk), .watchdog_clk_o(wdt_clk));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        @(posedge mclk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge mclk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic restart(input logic [3:0] c, input logic [1:0] s, input logic d, input int lim);
        resetn_i <= 1'b0;
        cks <= c;
        sut <= s;
        div8 <= d;
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
        n = 0;
        @(posedge mclk_i);
        while (busy !== 1'b0 && n < lim) begin
            @(posedge mclk_i);
            n++;
        end
    endtask

    function automatic clock_startup_pkg::source_t exp_src(input logic [3:0] c);
        if (c[3]) return clock_startup_pkg::SRC_XTAL;
        if (c[3:1] == 3'h3) return clock_startup_pkg::SRC_LF_XTAL;
        if (c == 4'h2) return clock_startup_pkg::SRC_RC;
        return clock_startup_pkg::SRC_EXT;
    endfunction

    initial begin
        failures = 0;
        comparisons = 0;
        cycles = 0;
        resetn_i = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, ext_int, usi_start} = 5'h00;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        {cks, sut, div8} = 7'h14;
        @(posedge mclk_i);
        for (int i = 0; i < 13; i++) begin
            restart(cks_tab[i], sut_tab[i], 1'(i & 1), (i < 6) ? 30000 : 300);
            xfer(1'b0, clock_startup_pkg::STATUS_OFFSET, 32'h0);
            if (i < 6) begin
                lo = 13 * 8 + ((wdt_tab[i] == 0) ? 0 : (wdt_tab[i] - 1) * 6);
                `CHK(n >= lo && n <= lo + 40, 1'b1)
                `CHK(src, exp_src(cks_tab[i]))
                ae = cks_tab[i][3] ? cks_tab[i][3:1] : 3'h0;
                `CHK(amp, ae)
                `CHK(d8_out, ~div8)
                `CHK(dom, 5'h1f)
                xfer(1'b0, clock_startup_pkg::CONFIG_OFFSET, 32'h0);
                exp = {19'h0, ae, 3'(exp_src(cks_tab[i])), div8, sut, cks};
                `CHK(rd, exp)
            end else begin
                `CHK(err, 1'b1)
                `CHK(dom.core, 1'b0)
                `CHK(rd[4:0], 5'h1c)
            end
            $display("fuse test %0d done", i);
        end
        restart(4'h2, 2'h2, 1'b0, 30000);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, clock_startup_pkg::CTRL_OFFSET, {28'h0, 1'b1, mode_tab[i]});
            repeat (2) @(posedge mclk_i);
            `CHK(dom, dom_tab[i])
            xfer(1'b0, clock_startup_pkg::STATUS_OFFSET, 32'h0);
            exp = {22'h0, dom_tab[i], 5'h06};
            `CHK(rd, exp)
            if (i & 1) ext_int <= 1'b1;
            else usi_start <= 1'b1;
            n = 0;
            @(posedge mclk_i);
            while (dom.core !== 1'b1 && n < 200) begin
                @(posedge mclk_i);
                n++;
            end
            ext_int <= 1'b0;
            usi_start <= 1'b0;
            `CHK(n >= wake_tab[i] && n < wake_tab[i] + 20, 1'b1)
            repeat (4) @(posedge mclk_i);
            $display("sleep test %0d done", i);
        end
        xfer(1'b0, clock_startup_pkg::CTRL_OFFSET, 32'h0);
        `CHK(rd, 32'h6)
        xfer(1'b1, clock_startup_pkg::STATUS_OFFSET, 32'hffffffff);
        xfer(1'b0, clock_startup_pkg::STATUS_OFFSET, 32'h0);
        `CHK(rd, 32'h3e2)
        xfer(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h0)
        $display("bus test done");
        print_verdict();
    end
endmodule

bind clock_source_startup_control clock_startup_properties #(
    .WDT_LONG_CYCLES(WDT_LONG_CYCLES), .XTAL_LONG_WAKE(XTAL_LONG_WAKE),
    .LF_LONG_WAKE(LF_LONG_WAKE)) props (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .domain_en_o(domain_en_o),
    .source_sel_o(source_sel_o), .crystal_amplifier_mode_bits_o(crystal_amplifier_mode_bits_o),
    .startup_busy_o(startup_busy_o), .config_error_o(config_error_o));
